// ### dhsp_pkg.sv
package dhsp_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int INSTR_NS = 122;
   // One instruction per system clock, never less than one cycle
   localparam int INSTR_CYC_RAW = (INSTR_NS * CLK_MHZ) / 1000;
   localparam int INSTR_CYC = (INSTR_CYC_RAW < 1) ? 1 : 1;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------
   // Program counter and stack
   // ----------------------------------------
   localparam int PC_W = 11;
   localparam logic [10:0] PC_RST = 11'h000;
   localparam logic [10:0] IRQ_VECTOR = 11'h100;
   localparam logic [10:0] PC_STEP = 11'h001;
   localparam int STK_DEPTH = 4;
   localparam logic [2:0] SP_RST = 3'h0;
   localparam logic [2:0] SP_FULL = 3'h4;

   // ----------------------------------------
   // Host port
   // ----------------------------------------
   localparam int HD_W = 8;
   localparam logic [7:0] DR_RST = 8'h00;
   localparam logic [15:0] STAT_RST = 16'h0000;
   // Status field positions in the 16-bit register
   localparam int ST_RQM = 15;
   localparam int ST_DMA = 14;
   localparam int ST_SOL = 13;
   localparam int ST_SIL = 12;
   localparam int ST_IE = 11;
   localparam int ST_GP1 = 10;
   localparam int ST_GP0 = 9;
   localparam int ST_HI = 8;

   // ----------------------------------------
   // Serial channel
   // ----------------------------------------
   localparam logic [4:0] LEN16 = 5'h10;
   localparam logic [4:0] LEN8 = 5'h08;
   localparam logic [4:0] CNT_RST = 5'h00;
   localparam logic [4:0] CNT_STEP = 5'h01;
   localparam logic [15:0] SH_RST = 16'h0000;

   // Synchroniser bit positions
   localparam int SY_W = 18;
   localparam int SY_CS = 0;
   localparam int SY_RD = 1;
   localparam int SY_WR = 2;
   localparam int SY_A0 = 3;
   localparam int SY_DMA_GRANT_N = 4;
   localparam int SY_INT = 5;
   localparam int SY_SCK = 6;
   localparam int SY_SI = 7;
   localparam int SY_SERIAL_IN_ENABLE_N = 8;
   localparam int SY_SERIAL_OUT_ENABLE_N = 9;
   localparam int SY_DAT = 10;
   // Idle level of every synchronised pin
   localparam logic [17:0] SY_RST = 18'h3FFDF;
endpackage

// ### dhsp_sync.sv
`timescale 1ns/1ps
module dhsp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import dhsp_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dhsp_sync_s;

   dhsp_sync_s q, n;

   // First stage feeds only the second stage
   always_comb
   begin
      n = q;
      n.meta = d_i;
      n.stable = q.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         q <= {RST_VAL, RST_VAL};
      end
      else
      begin
         q <= n;
      end
   end

   assign q_o = q.stable;
endmodule // dhsp_sync

// ### dhsp_top.sv
`timescale 1ns/1ps
// Contract
// - Every instruction takes exactly one system clock period.
// - Interrupt pin rising edge redirects execution only while enabled.
// - Accepted interrupt loads program counter with 100H, pushes return address unless the four-entry stack is full.
// - Host data port is eight-bit, three-state, steered by select and strobes.
// - Host reads and writes are accepted only while chip select or DMA grant is low.
// - Register select low reads data transfer, high reads status.
// - Select and read strobe low drive the chosen register out.
// - Select and write strobe low load the data transfer register.
// - Status is sixteen bits; only its upper byte reaches the host.
// - In DMA mode the DMA request output asks for a transfer.
// - DMA grant low acts like chip select low with register select low.
// - Master request flag follows host transfers even in DMA mode.
// - Serial input sampled on serial clock rising edge while input enabled.
// - Serial output shifts on falling edge while enabled, else three-stated.
// - Serial output request rises on load, falls when word is out.
// - Serial input length bit selects sixteen or eight bits.
// - Serial output length bit selects sixteen or eight bits.
// - Two general-purpose outputs follow program-set levels.
module dhsp_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Host pins
   input wire logic chip_select_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic register_select_line_i,
   input wire logic dma_grant_n_i,
   input wire logic [dhsp_pkg::HD_W-1:0] host_data_i,
   output logic [dhsp_pkg::HD_W-1:0] host_data_o,
   output logic host_data_oe_o,
   output logic dma_request_out_o,
   // Interrupt, serial and general-purpose pins
   input wire logic irq_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic serial_in_enable_n_i,
   input wire logic serial_out_enable_n_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output logic serial_out_request_o,
   output logic gp_out_0_o,
   output logic gp_out_1_o,
   // Program side control
   input wire logic irq_enable_bit_i,
   input wire logic serial_in_length_sel_i,
   input wire logic serial_out_length_sel_i,
   input wire logic dma_mode_i,
   input wire logic gp_level_0_i,
   input wire logic gp_level_1_i,
   input wire logic ret_i,
   input wire logic dr_load_i,
   input wire logic [dhsp_pkg::HD_W-1:0] dr_load_data_i,
   input wire logic so_load_i,
   input wire logic [15:0] so_load_data_i,
   output logic [dhsp_pkg::PC_W-1:0] pc_o,
   output logic irq_taken_o,
   output logic [dhsp_pkg::HD_W-1:0] dr_data_o,
   output logic dr_written_o,
   output logic [15:0] si_word_o,
   output logic si_valid_o
);
   import dhsp_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [10:0] pc;
      logic [3:0][10:0] stk;
      logic [2:0] sp;
      logic irq_take;
      logic int_prev;
      logic sck_prev;
      logic [15:0] stat;
      logic [7:0] dr;
      logic dr_wr;
      logic wr_act;
      logic rd_act;
      logic [7:0] dout;
      logic doe;
      logic dma_request_out;
      logic [15:0] si_sh;
      logic [4:0] si_cnt;
      logic [15:0] si_word;
      logic si_vld;
      logic [15:0] so_sh;
      logic [4:0] so_cnt;
      logic serial_out_request;
      logic so_bit;
      logic so_oe;
   } dhsp_state_s;

   dhsp_state_s q, n;
   logic [SY_W-1:0] pins_raw;
   logic [SY_W-1:0] pins;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign pins_raw = {host_data_i, serial_out_enable_n_i, serial_in_enable_n_i, serial_in_i,
                      serial_clk_i, irq_i, dma_grant_n_i, register_select_line_i,
                      write_strobe_n_i, read_strobe_n_i, chip_select_n_i};

   dhsp_sync #(
      .W(SY_W),
      .RST_VAL(SY_RST)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(pins_raw),
      .q_o(pins)
   );

   logic grant;
   logic host_sel;
   logic rd_now;
   logic wr_now;
   logic sck_rise;
   logic sck_fall;
   logic int_rise;
   logic [4:0] si_len;
   logic [4:0] so_len;

   always_comb
   begin
      grant = !pins[SY_DMA_GRANT_N];
      host_sel = !pins[SY_CS] || grant;
      rd_now = host_sel && !pins[SY_RD];
      wr_now = host_sel && !pins[SY_WR];
      sck_rise = pins[SY_SCK] && !q.sck_prev;
      sck_fall = !pins[SY_SCK] && q.sck_prev;
      int_rise = pins[SY_INT] && !q.int_prev;
      si_len = q.stat[ST_SIL] ? LEN8 : LEN16;
      so_len = q.stat[ST_SOL] ? LEN8 : LEN16;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      n = q;
      n.sck_prev = pins[SY_SCK];
      n.int_prev = pins[SY_INT];
      n.irq_take = 1'b0;
      n.dr_wr = 1'b0;
      n.si_vld = 1'b0;

      // One instruction per clock
      n.pc = q.pc + PC_STEP;
      if (ret_i && q.sp != SP_RST)
      begin
         n.pc = q.stk[q.sp[1:0] - 2'h1];
         n.sp = q.sp - 3'h1;
      end
      if (int_rise && q.stat[ST_IE])
      begin
         n.pc = IRQ_VECTOR;
         n.irq_take = 1'b1;
         if (q.sp != SP_FULL)
         begin
            n.stk[q.sp[1:0]] = q.pc + PC_STEP;
            n.sp = q.sp + 3'h1;
         end
      end

      // Program-set status bits; low byte never leaves the chip
      n.stat[ST_DMA] = dma_mode_i;
      n.stat[ST_SOL] = serial_out_length_sel_i;
      n.stat[ST_SIL] = serial_in_length_sel_i;
      n.stat[ST_IE] = irq_enable_bit_i;
      n.stat[ST_GP1] = gp_level_1_i;
      n.stat[ST_GP0] = gp_level_0_i;
      n.stat[ST_HI] = 1'b0;
      n.stat[7:0] = 8'h00;

      // Host port
      n.rd_act = rd_now;
      n.wr_act = wr_now;
      if (wr_now)
      begin
         n.dr = pins[SY_DAT +: HD_W];
      end
      if (rd_now)
      begin
         // Grant forces the data transfer register
         n.dout = (pins[SY_A0] && !grant) ? q.stat[15:8] : q.dr;
      end
      n.doe = rd_now;
      // Handshake ends when the strobe is released
      if ((q.rd_act && !rd_now) || (q.wr_act && !wr_now))
      begin
         n.stat[ST_RQM] = 1'b0;
         n.dr_wr = q.wr_act && !wr_now;
      end
      // Program load wins over a host clear in the same cycle
      if (dr_load_i)
      begin
         n.dr = dr_load_data_i;
         n.stat[ST_RQM] = 1'b1;
      end
      n.dma_request_out = n.stat[ST_DMA] && n.stat[ST_RQM];

      // Serial input
      if (sck_rise && !pins[SY_SERIAL_IN_ENABLE_N])
      begin
         n.si_sh = {q.si_sh[14:0], pins[SY_SI]};
         n.si_cnt = q.si_cnt + CNT_STEP;
         if (q.si_cnt + CNT_STEP == si_len)
         begin
            n.si_word = q.stat[ST_SIL] ? {8'h00, q.si_sh[6:0], pins[SY_SI]}
                                       : {q.si_sh[14:0], pins[SY_SI]};
            n.si_vld = 1'b1;
            n.si_cnt = CNT_RST;
         end
      end

      // Serial output, MSB of the selected length first
      n.so_oe = !pins[SY_SERIAL_OUT_ENABLE_N];
      if (sck_fall && !pins[SY_SERIAL_OUT_ENABLE_N] && q.serial_out_request)
      begin
         n.so_bit = q.stat[ST_SOL] ? q.so_sh[7] : q.so_sh[15];
         n.so_sh = {q.so_sh[14:0], 1'b0};
         n.so_cnt = q.so_cnt + CNT_STEP;
         if (q.so_cnt + CNT_STEP == so_len)
         begin
            n.serial_out_request = 1'b0;
            n.so_cnt = CNT_RST;
         end
      end
      if (so_load_i)
      begin
         n.so_sh = so_load_data_i;
         n.so_cnt = CNT_RST;
         n.serial_out_request = 1'b1;
      end
   end

   // is mapped onto the active-low synchronous reset by the chip wrapper
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.pc <= PC_RST;
         q.sp <= SP_RST;
         q.stat <= STAT_RST;
         q.dr <= DR_RST;
         q.int_prev <= 1'b0;
         q.sck_prev <= 1'b1;
         q.si_sh <= SH_RST;
         q.so_sh <= SH_RST;
         q.si_cnt <= CNT_RST;
         q.so_cnt <= CNT_RST;
      end
      else
      begin
         q <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign host_data_o = q.dout;
   assign host_data_oe_o = q.doe;
   assign dma_request_out_o = q.dma_request_out;
   assign serial_out_o = q.so_bit;
   assign serial_out_oe_o = q.so_oe;
   assign serial_out_request_o = q.serial_out_request;
   assign gp_out_0_o = q.stat[ST_GP0];
   assign gp_out_1_o = q.stat[ST_GP1];
   assign pc_o = q.pc;
   assign irq_taken_o = q.irq_take;
   assign dr_data_o = q.dr;
   assign dr_written_o = q.dr_wr;
   assign si_word_o = q.si_word;
   assign si_valid_o = q.si_vld;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   pc_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!ret_i && !(int_rise && q.stat[ST_IE])) |=> (q.pc == $past(q.pc) + PC_STEP))
      else $error("pc did not advance by one");

   irq_vector_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (int_rise && q.stat[ST_IE]) |=> (q.pc == IRQ_VECTOR && q.irq_take))
      else $error("enabled interrupt missed vector");

   irq_masked_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!q.stat[ST_IE]) |=> !q.irq_take)
      else $error("interrupt taken while disabled");

   host_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_now && !pins[SY_A0] && !grant) |=> (q.doe && q.dout == $past(q.dr)))
      else $error("read did not drive transfer register");

   host_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pins[SY_CS] && pins[SY_DMA_GRANT_N]) |=> !q.doe)
      else $error("data port driven without select");

   status_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_now && pins[SY_A0] && !grant) |=> (q.dout == $past(q.stat[15:8])))
      else $error("status read returned wrong byte");

   dma_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (q.stat[ST_DMA] && q.stat[ST_RQM]) |-> ##[0:1] q.dma_request_out)
      else $error("dma request not raised");

   rqm_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      dr_load_i |=> q.stat[ST_RQM])
      else $error("master request flag not set on load");

   serial_out_request_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      so_load_i |=> (q.serial_out_request && q.so_cnt == CNT_RST))
      else $error("output request not raised on load");

   so_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pins[SY_SERIAL_OUT_ENABLE_N] && !so_load_i) |=> ($stable(q.so_sh) && !q.so_oe))
      else $error("serial out moved while disabled");

   si_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pins[SY_SERIAL_IN_ENABLE_N] |=> ($stable(q.si_sh) && !q.si_vld))
      else $error("serial in moved while disabled");
endmodule // dhsp_top

// ### dhsp_partner.sv
`timescale 1ns/1ps
module dhsp_partner (
   input wire logic serial_out_i,
   output logic serial_clk_o,
   output logic serial_in_o,
   output logic serial_in_enable_n_o,
   output logic serial_out_enable_n_o
);
   logic [15:0] got;

   // Clock parks high and both enables stay high between frames
   initial
   begin
      serial_clk_o = 1'b1;
      serial_in_o = 1'b0;
      serial_in_enable_n_o = 1'b1;
      serial_out_enable_n_o = 1'b1;
      got = 16'h0000;
   end

   // ----------------------------------------
   // One frame, MSB first, 200 ns bit period
   // ----------------------------------------
   task automatic frame(input int n, input logic [15:0] din, input logic ien, input logic oen);
      int i;
      #7;
      serial_in_enable_n_o = ~ien;
      serial_out_enable_n_o = ~oen;
      #100;
      for (i = n - 1; i >= 0; i--)
      begin
         serial_clk_o = 1'b0;
         serial_in_o = din[i];
         #100;
         serial_clk_o = 1'b1;
         // Sample late in the bit: the device shows it a few clocks after the fall
         #90;
         got = {got[14:0], serial_out_i};
         #10;
      end
      // Released line must not keep the last bit
      serial_in_o = ~serial_in_o;
      serial_in_enable_n_o = 1'b1;
      serial_out_enable_n_o = 1'b1;
   endtask
endmodule // dhsp_partner

// ### test_dsp_host_serial_port.sv
`timescale 1ns/1ps
module test_dsp_host_serial_port;
   import dhsp_pkg::*;
   // Starts low without an event, so reset really spans three edges
   logic clk_i = 1'b0;
   logic rst_n_i, chip_select_n_i, read_strobe_n_i, write_strobe_n_i;
   logic register_select_line_i, dma_grant_n_i, dma_request_out_o, host_data_oe_o;
   logic [7:0] host_data_i, host_data_o, dr_load_data_i, dr_data_o;
   logic irq_i, serial_clk_i, serial_in_i, serial_in_enable_n_i, serial_out_enable_n_i;
   logic serial_out_o, serial_out_oe_o, serial_out_request_o, gp_out_0_o, gp_out_1_o;
   logic irq_enable_bit_i, serial_in_length_sel_i, serial_out_length_sel_i, dma_mode_i;
   logic gp_level_0_i, gp_level_1_i, ret_i, dr_load_i, so_load_i, irq_taken_o;
   logic dr_written_o, si_valid_o;
   logic [15:0] so_load_data_i, si_word_o;
   logic [10:0] pc_o, irq_pc, ret_pc, pc_prev;
   int fail_count = 0, compares = 0, si_cnt = 0, irq_cnt = 0, wr_cnt = 0, i, m;
   // Row: load, dma, out len, in len, irq en, gp1, gp0, then expected status byte
   logic [14:0] rows [5] = '{15'h0102, 15'h0204, 15'h0C18, 15'h70E0, 15'h4386};

   dhsp_top dut (.clk_i, .rst_n_i, .chip_select_n_i, .read_strobe_n_i, .write_strobe_n_i,
      .register_select_line_i, .dma_grant_n_i, .host_data_i, .host_data_o, .host_data_oe_o,
      .dma_request_out_o, .irq_i, .serial_clk_i, .serial_in_i, .serial_in_enable_n_i,
      .serial_out_enable_n_i, .serial_out_o, .serial_out_oe_o, .serial_out_request_o,
      .gp_out_0_o, .gp_out_1_o, .irq_enable_bit_i, .serial_in_length_sel_i,
      .serial_out_length_sel_i, .dma_mode_i, .gp_level_0_i, .gp_level_1_i, .ret_i,
      .dr_load_i, .dr_load_data_i, .so_load_i, .so_load_data_i, .pc_o, .irq_taken_o,
      .dr_data_o, .dr_written_o, .si_word_o, .si_valid_o);

   dhsp_partner p (
      .serial_out_i(serial_out_o),
      .serial_clk_o(serial_clk_i),
      .serial_in_o(serial_in_i),
      .serial_in_enable_n_o(serial_in_enable_n_i),
      .serial_out_enable_n_o(serial_out_enable_n_i)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // One-cycle pulses are counted here so no wait can miss them
   always @(posedge clk_i)
   begin
      if (si_valid_o === 1'b1) si_cnt++;
      if (dr_written_o === 1'b1) wr_cnt++;
      if (irq_taken_o === 1'b1)
      begin
         irq_cnt++;
         irq_pc = pc_o;
         ret_pc = pc_prev + 11'h001;
      end
      pc_prev = pc_o;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic wait_c(ref int c, input int v);
      int k;
      for (k = 0; k < 200 && c != v; k++) @(negedge clk_i);
      if (c != v)
      begin
         $display("BAD wait_count expected %0d seen %0d", v, c);
         fail_count++;
         end_sim();
      end
   endtask

   task automatic wait_oe(input logic v);
      int k;
      for (k = 0; k < 20 && host_data_oe_o !== v; k++) @(negedge clk_i);
      if (host_data_oe_o !== v)
      begin
         $display("BAD host_data_oe_o expected %b seen %b", v, host_data_oe_o);
         fail_count++;
         end_sim();
      end
   endtask

   task automatic host_rd(input logic a0, input logic dma_grant_n, input logic [7:0] exp);
      @(negedge clk_i);
      register_select_line_i = a0;
      chip_select_n_i = dma_grant_n;
      dma_grant_n_i = ~dma_grant_n;
      read_strobe_n_i = 1'b0;
      wait_oe(1'b1);
      chk("host_data_o", 16'(exp), 16'(host_data_o));
      tick(2);
      read_strobe_n_i = 1'b1;
      chip_select_n_i = 1'b1;
      dma_grant_n_i = 1'b1;
      wait_oe(1'b0);
      tick(2);
   endtask

   task automatic host_wr(input logic [7:0] d, input logic sel);
      int w;
      w = wr_cnt;
      @(negedge clk_i);
      host_data_i = d;
      chip_select_n_i = ~sel;
      write_strobe_n_i = 1'b0;
      tick(4);
      write_strobe_n_i = 1'b1;
      chip_select_n_i = 1'b1;
      host_data_i = ~d;
      tick(6);
      chk("dr_written", 16'(sel), 16'(wr_cnt - w));
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {chip_select_n_i, read_strobe_n_i, write_strobe_n_i, dma_grant_n_i} = 4'hF;
      {irq_i, irq_enable_bit_i, serial_in_length_sel_i, serial_out_length_sel_i} = 4'h0;
      {dma_mode_i, gp_level_0_i, gp_level_1_i, ret_i, dr_load_i, so_load_i} = 6'h00;
      register_select_line_i = 1'b0;
      host_data_i = 8'h00;
      dr_load_data_i = 8'h5A;
      so_load_data_i = 16'hB4E1;
      rst_n_i = 1'b0;
      tick(3);
      chk("reset_outs", 16'h0000, 16'({host_data_oe_o, dma_request_out_o,
         serial_out_request_o, serial_out_oe_o, pc_o}));
      rst_n_i = 1'b1;
      tick(4);
      m = int'(pc_o);
      tick(1);
      chk("pc_step", 16'(m + 1), 16'(pc_o));
      for (i = 0; i < 5; i++)
      begin
         {dma_mode_i, serial_out_length_sel_i, serial_in_length_sel_i, irq_enable_bit_i,
            gp_level_1_i, gp_level_0_i} = rows[i][13:8];
         dr_load_i = rows[i][14];
         tick(1);
         dr_load_i = 1'b0;
         tick(2);
         chk("gp_out", 16'(rows[i][9:8]), 16'({gp_out_1_o, gp_out_0_o}));
         chk("dma_request", 16'(rows[i][14] & rows[i][13]), 16'(dma_request_out_o));
         host_rd(1'b1, 1'b0, rows[i][7:0]);
      end
      {dma_mode_i, serial_out_length_sel_i, serial_in_length_sel_i, irq_enable_bit_i} = 4'h0;
      // Strobes without any select
      read_strobe_n_i = 1'b0;
      tick(6);
      chk("oe_no_select", 16'h0000, 16'(host_data_oe_o));
      read_strobe_n_i = 1'b1;
      host_wr(8'h77, 1'b0);
      chk("dr_kept", 16'h005A, 16'(dr_data_o));
      host_wr(8'hC3, 1'b1);
      chk("dr_written_data", 16'h00C3, 16'(dr_data_o));
      host_rd(1'b0, 1'b0, 8'hC3);
      // Grant reads the transfer register whatever the select line says
      dma_mode_i = 1'b1;
      dr_load_i = 1'b1;
      dr_load_data_i = 8'h3C;
      tick(1);
      dr_load_i = 1'b0;
      tick(3);
      chk("dma_request_set", 16'h0001, 16'(dma_request_out_o));
      host_rd(1'b1, 1'b1, 8'h3C);
      chk("dma_request_clr", 16'h0000, 16'(dma_request_out_o));
      dma_mode_i = 1'b0;
      irq_i = 1'b1;
      tick(6);
      chk("irq_masked", 16'h0000, 16'(irq_cnt));
      irq_i = 1'b0;
      irq_enable_bit_i = 1'b1;
      tick(4);
      irq_i = 1'b1;
      wait_c(irq_cnt, 1);
      chk("irq_vector", 16'h0100, 16'(irq_pc));
      irq_i = 1'b0;
      ret_i = 1'b1;
      tick(1);
      chk("ret_pc", 16'(ret_pc), 16'(pc_o));
      ret_i = 1'b0;
      for (m = 0; m < 2; m++)
      begin
         serial_in_length_sel_i = m[0];
         serial_out_length_sel_i = m[0];
         so_load_i = 1'b1;
         tick(1);
         so_load_i = 1'b0;
         tick(2);
         chk("so_request_set", 16'h0001, 16'(serial_out_request_o));
         i = si_cnt;
         p.frame(m ? 8 : 16, 16'h9C36, 1'b1, 1'b1);
         wait_c(si_cnt, i + 1);
         tick(4);
         chk("si_word", m ? 16'h0036 : 16'h9C36, si_word_o);
         chk("so_word", m ? 16'h00E1 : 16'hB4E1, m ? 16'(p.got[7:0]) : p.got);
         chk("so_request_clr", 16'h0000, 16'(serial_out_request_o));
         chk("so_oe_off", 16'h0000, 16'(serial_out_oe_o));
      end
      {serial_in_length_sel_i, serial_out_length_sel_i} = 2'h0;
      so_load_i = 1'b1;
      tick(1);
      so_load_i = 1'b0;
      i = si_cnt;
      p.frame(16, 16'h1234, 1'b0, 1'b0);
      tick(6);
      chk("si_disabled", 16'(i), 16'(si_cnt));
      chk("so_request_held", 16'h0001, 16'(serial_out_request_o));
      p.frame(16, 16'h0000, 1'b0, 1'b1);
      tick(4);
      chk("so_word_late", 16'hB4E1, p.got);
      chk("so_request_end", 16'h0000, 16'(serial_out_request_o));
      // Mid-run reset drops a pending request and the transfer register
      so_load_i = 1'b1;
      tick(1);
      so_load_i = 1'b0;
      rst_n_i = 1'b0;
      tick(3);
      chk("reset_mid", 16'h0000, 16'({serial_out_request_o, host_data_oe_o, dr_data_o}));
      rst_n_i = 1'b1;
      tick(1);
      chk("pc_restart", 16'h0001, 16'(pc_o));
      end_sim();
   end
endmodule // test_dsp_host_serial_port
